// ### logic/otc_output_terminals.sv
`timescale 1ns/1ns
module otc_output_terminals
#(
	parameter int DELAY_TICK_CYCLES = otc_pkg::DELAY_TICK_CYCLES,
	parameter int SRC_COUNT         = otc_pkg::SRC_COUNT
)
(
	input  wire logic                        clk_sys_in,
	input  wire logic                        reset_in,
	input  wire logic                        cfg_write_in,
	input  wire otc_pkg::otc_cfg_t           cfg_in,
	input  wire otc_pkg::otc_refs_t          refs_in,
	input  wire logic [SRC_COUNT-1:0][15:0]  meas_in,
	input  wire logic [3:0]                  switch_state_in,
	output logic                             multiplex_output_terminal_out,
	output logic                             open_collector_output_one_out,
	output logic                             relay_one_contacts_out,
	output logic                             relay_two_out,
	output logic [16:0]                      analog_output_one_out,
	output logic [16:0]                      analog_output_two_out,
	output otc_pkg::otc_cfg_t                cfg_out
);

	localparam int TW = $clog2(DELAY_TICK_CYCLES + 1);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic signed [10:0] clamp_s(input logic signed [10:0] v,
		input logic signed [10:0] lim);
		if (v > lim)
			return lim;
		else if (v < -lim)
			return -lim;
		return v;
	endfunction : clamp_s

	// Numerator and denominator giving the source in 0.1 % of full range
	function automatic logic [63:0] norm_terms(input logic [3:0] code,
		input logic [SRC_COUNT-1:0][15:0] meas, input otc_pkg::otc_refs_t refs);
		logic [31:0] raw;
		logic [31:0] num;
		logic [31:0] den;
		raw = 32'(meas[code]) * otc_pkg::PCT_FULL_W;
		num = raw;
		den = 32'h0000_0001;
		case (code)
			otc_pkg::SRC_RUN_FREQ,
			otc_pkg::SRC_SET_FREQ:  den = 32'(refs.max_freq);
			otc_pkg::SRC_CURRENT:   den = 32'(refs.rated_current) * 32'(otc_pkg::RATED_DEN_MUL);
			otc_pkg::SRC_TORQUE:    den = 32'(refs.rated_torque) * 32'(otc_pkg::RATED_DEN_MUL);
			otc_pkg::SRC_POWER:     den = 32'(refs.rated_power) * 32'(otc_pkg::RATED_DEN_MUL);
			otc_pkg::SRC_VOLTAGE:
			begin
				num = raw * 32'(otc_pkg::VOLT_NUM_MUL);
				den = 32'(refs.rated_voltage) * 32'(otc_pkg::VOLT_DEN_MUL);
			end
			otc_pkg::SRC_PULSE_IN:  den = 32'(otc_pkg::PULSE_IN_FULL);
			otc_pkg::SRC_AIN_ONE,
			otc_pkg::SRC_AIN_TWO:   den = 32'(otc_pkg::AIN_FULL);
			otc_pkg::SRC_LENGTH:    den = 32'(refs.max_length);
			otc_pkg::SRC_COUNT_VAL: den = 32'(refs.max_count);
			otc_pkg::SRC_COMM:      den = 32'(otc_pkg::COMM_FULL);
			otc_pkg::SRC_SPEED:     den = 32'(refs.max_speed);
			otc_pkg::SRC_ABS_CURR:  den = 32'(otc_pkg::ABS_CURR_FULL);
			otc_pkg::SRC_BUS_VOLT:  den = 32'(otc_pkg::BUS_VOLT_FULL);
			default:                num = '0;	// Reserved code reads as zero
		endcase
		return {num, den};
	endfunction : norm_terms

	// Corrected analog level, clamped to the 0 to 10 V span
	function automatic logic [16:0] ao_level(input logic [9:0] pct,
		input logic signed [10:0] gain, input logic signed [10:0] offset);
		logic signed [23:0] y;
		y = $signed(24'(gain)) * $signed({14'h0000, pct})
			+ $signed(24'(offset)) * otc_pkg::OFFSET_SCALE;
		if (y < 0)
			return '0;
		else if (y > $signed({7'h00, otc_pkg::AO_FULL}))
			return otc_pkg::AO_FULL;
		return y[16:0];
	endfunction : ao_level

	function automatic logic pol_negative(input logic [16:0] pol, input int weight);
		return ((int'(pol) / weight) % otc_pkg::POL_RADIX) == otc_pkg::POL_NEGATIVE;
	endfunction : pol_negative

	// ------------------------------------------------------------
	// Configuration
	// ------------------------------------------------------------
	otc_pkg::otc_cfg_t cfg;
	otc_pkg::otc_cfg_t next_cfg;

	// Out-of-range settings are clamped so the pulse limit always holds
	always_comb
	begin
		next_cfg = cfg;
		if (cfg_write_in)
		begin
			next_cfg = cfg_in;
			if (cfg_in.pulse_fmax < otc_pkg::PULSE_FMIN)
				next_cfg.pulse_fmax = otc_pkg::PULSE_FMIN;
			else if (cfg_in.pulse_fmax > otc_pkg::PULSE_FMAX_LIMIT)
				next_cfg.pulse_fmax = otc_pkg::PULSE_FMAX_LIMIT;
			next_cfg.ao1_offset = clamp_s(cfg_in.ao1_offset, otc_pkg::OFFSET_LIMIT);
			next_cfg.ao2_offset = clamp_s(cfg_in.ao2_offset, otc_pkg::OFFSET_LIMIT);
			next_cfg.ao1_gain   = clamp_s(cfg_in.ao1_gain, otc_pkg::GAIN_LIMIT);
			next_cfg.ao2_gain   = clamp_s(cfg_in.ao2_gain, otc_pkg::GAIN_LIMIT);
			for (int i = 0; i < otc_pkg::SW_COUNT; i++)
			begin
				if (cfg_in.delay[i] > otc_pkg::DELAY_LIMIT)
					next_cfg.delay[i] = otc_pkg::DELAY_LIMIT;
			end
		end
	end

	// Reset loads defaults, second analog source included
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
			cfg <= otc_pkg::CFG_DEFAULT;
		else
			cfg <= next_cfg;
	end

	// ------------------------------------------------------------
	// Delay tick, one pulse per 0.1 s
	// ------------------------------------------------------------
	logic [TW-1:0] tick_count;
	logic [TW-1:0] next_tick_count;
	logic          tick;
	logic          next_tick;

	always_comb
	begin
		next_tick       = (tick_count == TW'(DELAY_TICK_CYCLES - 1));
		next_tick_count = next_tick ? '0 : tick_count + 1'b1;
	end

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			tick_count <= '0;
			tick       <= 1'b0;
		end
		else
		begin
			tick_count <= next_tick_count;
			tick       <= next_tick;
		end
	end

	// ------------------------------------------------------------
	// Shared serial divider
	// ------------------------------------------------------------
	// One divider serves all four channels in turn; slow sources make
	// the 136-cycle round trip per channel invisible at the terminals.
	otc_pkg::otc_div_state_t div_state;
	otc_pkg::otc_div_state_t next_div_state;
	logic [1:0]       div_chan;
	logic [1:0]       next_div_chan;
	logic [31:0]      div_den;
	logic [31:0]      next_div_den;
	logic [31:0]      div_quo;
	logic [31:0]      next_div_quo;
	logic [32:0]      div_rem;
	logic [32:0]      next_div_rem;
	logic [5:0]       div_step;
	logic [5:0]       next_div_step;
	logic [2:0][9:0]  pct;
	logic [2:0][9:0]  next_pct;
	logic [21:0]      half_period;
	logic [21:0]      next_half_period;
	logic [63:0]      terms;
	logic [32:0]      shifted;

	always_comb
	begin
		next_div_state   = div_state;
		next_div_chan    = div_chan;
		next_div_den     = div_den;
		next_div_quo     = div_quo;
		next_div_rem     = div_rem;
		next_div_step    = div_step;
		next_pct         = pct;
		next_half_period = half_period;
		terms            = '0;
		shifted          = '0;
		case (div_state)
			otc_pkg::DIV_LOAD:
			begin
				case (div_chan)
					2'h0:    terms = norm_terms(cfg.pulse_src, meas_in, refs_in);
					2'h1:    terms = norm_terms(cfg.ao1_src, meas_in, refs_in);
					2'h2:    terms = norm_terms(cfg.ao2_src, meas_in, refs_in);
					default: terms = {otc_pkg::HALF_PERIOD_NUM, otc_pkg::PULSE_BASE_DEN
						+ 32'(pct[0]) * 32'(cfg.pulse_fmax - otc_pkg::PULSE_FMIN)};
				endcase
				next_div_quo   = terms[63:32];
				next_div_den   = terms[31:0];
				next_div_rem   = '0;
				next_div_step  = '0;
				next_div_state = otc_pkg::DIV_RUN;
			end
			otc_pkg::DIV_RUN:
			begin
				shifted = {div_rem[31:0], div_quo[31]};
				if (shifted >= {1'b0, div_den})
				begin
					next_div_rem = shifted - {1'b0, div_den};
					next_div_quo = {div_quo[30:0], 1'b1};
				end
				else
				begin
					next_div_rem = shifted;
					next_div_quo = {div_quo[30:0], 1'b0};
				end
				next_div_step = div_step + 6'h01;
				if (div_step == 6'(otc_pkg::DIV_STEPS - 1))
					next_div_state = otc_pkg::DIV_STORE;
			end
			otc_pkg::DIV_STORE:
			begin
				if (div_chan == 2'h3)
				begin
					if (div_quo > 32'(otc_pkg::HALF_PERIOD_MAX))
						next_half_period = otc_pkg::HALF_PERIOD_MAX;
					else if (div_quo < 32'(otc_pkg::HALF_PERIOD_MIN))
						next_half_period = otc_pkg::HALF_PERIOD_MIN;
					else
						next_half_period = div_quo[21:0];
				end
				else if (div_den == '0)
					next_pct[div_chan] = '0;	// Missing reference reads as zero
				else if (div_quo > otc_pkg::PCT_FULL_W)
					next_pct[div_chan] = otc_pkg::PCT_FULL;	// Over-range saturates
				else
					next_pct[div_chan] = div_quo[9:0];
				next_div_chan  = div_chan + 2'h1;
				next_div_state = otc_pkg::DIV_LOAD;
			end
			default: next_div_state = otc_pkg::DIV_LOAD;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			div_state   <= otc_pkg::DIV_LOAD;
			div_chan    <= '0;
			div_den     <= '0;
			div_quo     <= '0;
			div_rem     <= '0;
			div_step    <= '0;
			pct         <= '0;
			half_period <= otc_pkg::HALF_PERIOD_MAX;
		end
		else
		begin
			div_state   <= next_div_state;
			div_chan    <= next_div_chan;
			div_den     <= next_div_den;
			div_quo     <= next_div_quo;
			div_rem     <= next_div_rem;
			div_step    <= next_div_step;
			pct         <= next_pct;
			half_period <= next_half_period;
		end
	end

	// ------------------------------------------------------------
	// Pulse role square wave
	// ------------------------------------------------------------
	logic [21:0] pulse_count;
	logic [21:0] next_pulse_count;
	logic [21:0] pulse_half;
	logic [21:0] next_pulse_half;
	logic        pulse_level;
	logic        next_pulse_level;

	// A shorter new period ends the half early: prompt start, no half below the shorter period
	always_comb
	begin
		next_pulse_count = pulse_count + 22'h000001;
		next_pulse_half  = pulse_half;
		next_pulse_level = pulse_level;
		if (pulse_count >= pulse_half - 22'h000001 || pulse_count >= half_period - 22'h000001)
		begin
			next_pulse_count = '0;
			next_pulse_level = ~pulse_level;
			next_pulse_half  = half_period;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pulse_count <= '0;
			pulse_half  <= otc_pkg::HALF_PERIOD_MAX;
			pulse_level <= 1'b0;
		end
		else
		begin
			pulse_count <= next_pulse_count;
			pulse_half  <= next_pulse_half;
			pulse_level <= next_pulse_level;
		end
	end

	// ------------------------------------------------------------
	// Switch delays, one per output
	// ------------------------------------------------------------
	logic [otc_pkg::SW_COUNT-1:0] delayed;

	for (genvar i = 0; i < otc_pkg::SW_COUNT; i++)
	begin : g_delay
		otc_switch_delay u_delay
		(
			.clk_sys_in (clk_sys_in),
			.reset_in   (reset_in),
			.tick_in    (tick),
			.state_in   (switch_state_in[i]),
			.delay_in   (cfg.delay[i]),
			.level_out  (delayed[i])
		);
	end

	// ------------------------------------------------------------
	// Terminal drivers, 1 means terminal closed to common
	// ------------------------------------------------------------
	logic        next_mux;
	logic        next_oc1;
	logic        next_relay1;
	logic        next_relay2;
	logic [16:0] next_ao1;
	logic [16:0] next_ao2;

	// Second relay has no polarity digit and stays positive logic
	always_comb
	begin
		next_oc1    = delayed[otc_pkg::SW_OC]
			^ pol_negative(cfg.polarity, otc_pkg::POL_W_OC);
		next_relay1 = delayed[otc_pkg::SW_RELAY1]
			^ pol_negative(cfg.polarity, otc_pkg::POL_W_RELAY1);
		next_relay2 = delayed[otc_pkg::SW_RELAY2];
		if (cfg.mux_mode == otc_pkg::OTC_MODE_PULSE)
			next_mux = pulse_level;
		else
			next_mux = delayed[otc_pkg::SW_MUX]
				^ pol_negative(cfg.polarity, otc_pkg::POL_W_MUX);
		next_ao1 = ao_level(pct[1], cfg.ao1_gain, cfg.ao1_offset);
		next_ao2 = ao_level(pct[2], cfg.ao2_gain, cfg.ao2_offset);
	end

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			multiplex_output_terminal_out <= 1'b0;
			open_collector_output_one_out <= 1'b0;
			relay_one_contacts_out        <= 1'b0;
			relay_two_out                 <= 1'b0;
			analog_output_one_out         <= '0;
			analog_output_two_out         <= '0;
			cfg_out                       <= otc_pkg::CFG_DEFAULT;
		end
		else
		begin
			multiplex_output_terminal_out <= next_mux;
			open_collector_output_one_out <= next_oc1;
			relay_one_contacts_out        <= next_relay1;
			relay_two_out                 <= next_relay2;
			analog_output_one_out         <= next_ao1;
			analog_output_two_out         <= next_ao2;
			cfg_out                       <= next_cfg;
		end
	end

endmodule : otc_output_terminals

// ### inc/otc_pkg.sv
package otc_pkg;

	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	// Switch delays are counted in tenths of a second
	localparam int DELAY_TICK_NS     = 100_000_000;
	localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;
	localparam logic [15:0] DELAY_LIMIT   = 16'h8ca0;	// 3600.0 s
	localparam logic [15:0] DELAY_DEFAULT = 16'h0000;	// 0.0 s

	// ------------------------------------------------------------
	// Normalised level: 0.1 % steps, 1000 is full range
	// ------------------------------------------------------------
	localparam int         PCT_FULL_INT = 1000;
	localparam logic [9:0] PCT_FULL     = 10'h3e8;
	localparam logic [31:0] PCT_FULL_W  = 32'h0000_03e8;

	// ------------------------------------------------------------
	// Pulse role, frequencies in 0.01 kHz steps
	// ------------------------------------------------------------
	localparam int          PULSE_UNIT_HZ      = 10;
	localparam int          PULSE_FMIN_INT     = 1;
	localparam logic [13:0] PULSE_FMIN         = 14'h0001;	// 0.01 kHz
	localparam logic [13:0] PULSE_FMAX_LIMIT   = 14'h2710;	// 100.00 kHz
	localparam logic [13:0] PULSE_FMAX_DEFAULT = 14'h1388;	// 50.00 kHz
	// Half period = HALF_PERIOD_NUM / (fmin*1000 + pct*(fmax-fmin))
	localparam logic [31:0] HALF_PERIOD_NUM =
		32'(64'(CLK_HZ) * 64'(PCT_FULL_INT) / 64'(2 * PULSE_UNIT_HZ));
	localparam logic [31:0] PULSE_BASE_DEN  = 32'(PULSE_FMIN_INT * PCT_FULL_INT);
	localparam logic [21:0] HALF_PERIOD_MAX = 22'h3fffff;
	localparam logic [21:0] HALF_PERIOD_MIN = 22'h000001;

	// ------------------------------------------------------------
	// Analog outputs: level in 0.001 % steps, 100000 is 10 V
	// ------------------------------------------------------------
	localparam logic        [16:0] AO_FULL        = 17'h186a0;
	localparam logic signed [23:0] OFFSET_SCALE   = 24'h000064;
	localparam logic signed [10:0] OFFSET_LIMIT   = 11'h3e8;	// 100.0 %
	localparam logic signed [10:0] OFFSET_DEFAULT = 11'h000;
	localparam logic signed [10:0] GAIN_LIMIT     = 11'h3e8;	// 10.00
	localparam logic signed [10:0] GAIN_DEFAULT   = 11'h064;	// 1.00

	// ------------------------------------------------------------
	// Source codes and their scaling
	// ------------------------------------------------------------
	localparam int SRC_COUNT = 16;
	localparam logic [3:0] SRC_RUN_FREQ  = 4'h0;
	localparam logic [3:0] SRC_SET_FREQ  = 4'h1;
	localparam logic [3:0] SRC_CURRENT   = 4'h2;
	localparam logic [3:0] SRC_TORQUE    = 4'h3;
	localparam logic [3:0] SRC_POWER     = 4'h4;
	localparam logic [3:0] SRC_VOLTAGE   = 4'h5;
	localparam logic [3:0] SRC_PULSE_IN  = 4'h6;
	localparam logic [3:0] SRC_AIN_ONE   = 4'h7;
	localparam logic [3:0] SRC_AIN_TWO   = 4'h8;
	localparam logic [3:0] SRC_LENGTH    = 4'ha;
	localparam logic [3:0] SRC_COUNT_VAL = 4'hb;
	localparam logic [3:0] SRC_COMM      = 4'hc;
	localparam logic [3:0] SRC_SPEED     = 4'hd;
	localparam logic [3:0] SRC_ABS_CURR  = 4'he;
	localparam logic [3:0] SRC_BUS_VOLT  = 4'hf;
	localparam logic [3:0] RATED_DEN_MUL = 4'h2;	// twice rated value
	localparam logic [3:0] VOLT_NUM_MUL  = 4'ha;	// 1.2 = 12 / 10
	localparam logic [3:0] VOLT_DEN_MUL  = 4'hc;
	localparam logic [15:0] PULSE_IN_FULL = 16'h2710;	// 100.00 kHz
	localparam logic [15:0] AIN_FULL      = 16'h03e8;	// 10.00 V
	localparam logic [15:0] COMM_FULL     = 16'h03e8;	// 100.0 %
	localparam logic [15:0] ABS_CURR_FULL = 16'h2710;	// 1000.0 A
	localparam logic [15:0] BUS_VOLT_FULL = 16'h2710;	// 1000.0 V

	// ------------------------------------------------------------
	// Switch outputs and polarity digits
	// ------------------------------------------------------------
	localparam int SW_COUNT  = 4;
	localparam int SW_OC     = 0;
	localparam int SW_RELAY1 = 1;
	localparam int SW_RELAY2 = 2;
	localparam int SW_MUX    = 3;
	localparam int POL_W_OC     = 1;
	localparam int POL_W_RELAY1 = 10;
	localparam int POL_W_MUX    = 10000;
	localparam int POL_RADIX    = 10;
	localparam int POL_NEGATIVE = 1;
	localparam int DIV_STEPS    = 32;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic {OTC_MODE_PULSE, OTC_MODE_SWITCH} otc_mux_mode_t;

	typedef enum logic [1:0] {DIV_LOAD, DIV_RUN, DIV_STORE} otc_div_state_t;

	typedef struct packed {
		otc_mux_mode_t         mux_mode;
		logic [3:0]            pulse_src;
		logic [3:0]            ao1_src;
		logic [3:0]            ao2_src;
		logic [13:0]           pulse_fmax;
		logic signed [10:0]    ao1_offset;
		logic signed [10:0]    ao1_gain;
		logic signed [10:0]    ao2_offset;
		logic signed [10:0]    ao2_gain;
		logic [3:0][15:0]      delay;
		logic [16:0]           polarity;
	} otc_cfg_t;

	typedef struct packed {
		logic [15:0] max_freq;
		logic [15:0] rated_current;
		logic [15:0] rated_torque;
		logic [15:0] rated_power;
		logic [15:0] rated_voltage;
		logic [15:0] max_length;
		logic [15:0] max_count;
		logic [15:0] max_speed;
	} otc_refs_t;

	localparam otc_cfg_t CFG_DEFAULT = '{
		mux_mode:   OTC_MODE_PULSE,
		pulse_src:  SRC_RUN_FREQ,
		ao1_src:    SRC_RUN_FREQ,
		ao2_src:    SRC_SET_FREQ,
		pulse_fmax: PULSE_FMAX_DEFAULT,
		ao1_offset: OFFSET_DEFAULT,
		ao1_gain:   GAIN_DEFAULT,
		ao2_offset: OFFSET_DEFAULT,
		ao2_gain:   GAIN_DEFAULT,
		delay:      {4{DELAY_DEFAULT}},
		polarity:   17'h00000
	};

endpackage : otc_pkg

// ### logic/otc_switch_delay.sv
`timescale 1ns/1ns
module otc_switch_delay
(
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic        tick_in,
	input  wire logic        state_in,
	input  wire logic [15:0] delay_in,
	output logic             level_out
);

	logic [15:0] tick_count;
	logic [15:0] next_tick_count;
	logic        next_level;

	// ------------------------------------------------------------
	// Persistence timer
	// ------------------------------------------------------------
	// A state that flips back before the delay expires restarts the wait
	always_comb
	begin
		next_level      = level_out;
		next_tick_count = tick_count;
		if (state_in == level_out)
			next_tick_count = '0;
		else if (tick_count >= delay_in)
		begin
			next_level      = state_in;
			next_tick_count = '0;
		end
		else if (tick_in)
			next_tick_count = tick_count + 16'h0001;
	end

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			level_out  <= 1'b0;
			tick_count <= '0;
		end
		else
		begin
			level_out  <= next_level;
			tick_count <= next_tick_count;
		end
	end

endmodule : otc_switch_delay

// ### test/otc_plant.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Field wiring model
// ------------------------------------------------------------
// Pulled-up inputs read low while a terminal is closed to common
module otc_plant
(
	input  wire logic [3:0] closed_in,
	output logic      [3:0] pin_level_out
);
	assign pin_level_out = ~closed_in;
endmodule : otc_plant

// ### test/otc_chk.sv
`timescale 1ns/1ns
module otc_chk
(
	input wire logic              clk_sys_in,
	input wire logic              reset_in,
	input wire logic              cfg_write_in,
	input wire otc_pkg::otc_cfg_t cfg_in,
	input wire logic [3:0]        switch_state_in,
	input wire logic              multiplex_output_terminal_out,
	input wire logic              relay_two_out,
	input wire logic [16:0]       analog_output_one_out,
	input wire logic [16:0]       analog_output_two_out,
	input wire otc_pkg::otc_cfg_t cfg_out
);
	logic [8:0] run;
	logic [1:0] seen;	// Changes seen in pulse mode, saturating at two
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	// ------------------------------------------------------------
	// Cycles since the terminal last moved, saturating
	// ------------------------------------------------------------
	// Entering pulse mode and the first toggle after it may come early, so skip both
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			run  <= 9'h000;
			seen <= 2'h0;
		end
		else
		begin
			run <= $changed(multiplex_output_terminal_out) ? 9'h000 : run + {8'h00, run != 9'h1ff};
			if (cfg_out.mux_mode != otc_pkg::OTC_MODE_PULSE)
				seen <= 2'h0;
			else if ($changed(multiplex_output_terminal_out) && seen != 2'h2)
				seen <= seen + 2'h1;
		end
	end
	a_mode_load: assert property (cfg_write_in |=> cfg_out.mux_mode == $past(cfg_in.mux_mode))
		else $error("mode not loaded");
	a_src_load: assert property (cfg_write_in |=> cfg_out.ao2_src == $past(cfg_in.ao2_src))
		else $error("source not loaded");
	a_fmax_span: assert property (cfg_out.pulse_fmax inside {[14'h0001:14'h2710]})
		else $error("fmax out of span");
	a_gain_clamp: assert property (cfg_write_in && cfg_in.ao1_gain > otc_pkg::GAIN_LIMIT
		|=> cfg_out.ao1_gain == otc_pkg::GAIN_LIMIT)
		else $error("gain not clamped");
	a_offset_clamp: assert property (cfg_write_in && cfg_in.ao1_offset < -otc_pkg::OFFSET_LIMIT
		|=> cfg_out.ao1_offset == -otc_pkg::OFFSET_LIMIT)
		else $error("offset not clamped");
	a_delay_clamp: assert property (cfg_write_in && cfg_in.delay[1] > otc_pkg::DELAY_LIMIT
		|=> cfg_out.delay[1] == otc_pkg::DELAY_LIMIT)
		else $error("delay not clamped");
	a_level_span: assert property (analog_output_one_out <= otc_pkg::AO_FULL
		&& analog_output_two_out <= otc_pkg::AO_FULL)
		else $error("level above 10 V");
	a_relay_follow: assert property ((cfg_out.delay[2] == 16'h0000 && $stable(switch_state_in[2]))[*3]
		|-> relay_two_out == switch_state_in[2])
		else $error("relay two not following");
	a_switch_role: assert property ((cfg_out.mux_mode == otc_pkg::OTC_MODE_SWITCH
		&& cfg_out.polarity == 17'h00000 && cfg_out.delay[3] == 16'h0000
		&& $stable(switch_state_in[3]))[*3]
		|-> multiplex_output_terminal_out == switch_state_in[3])
		else $error("switch role wrong");
	a_pulse_limit: assert property (cfg_out.mux_mode == otc_pkg::OTC_MODE_PULSE
		&& seen == 2'h2
		&& $changed(multiplex_output_terminal_out) |-> run >= 9'h0f9)
		else $error("pulse above 100 kHz");
	c_write: cover property (cfg_write_in);
	c_switch: cover property (cfg_out.mux_mode == otc_pkg::OTC_MODE_SWITCH
		&& $rose(multiplex_output_terminal_out));
	c_level: cover property (analog_output_two_out == 17'h15f90);
endmodule : otc_chk
bind otc_output_terminals otc_chk i_otc_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
	.cfg_write_in(cfg_write_in), .cfg_in(cfg_in), .switch_state_in(switch_state_in),
	.multiplex_output_terminal_out(multiplex_output_terminal_out), .relay_two_out(relay_two_out),
	.analog_output_one_out(analog_output_one_out),
	.analog_output_two_out(analog_output_two_out), .cfg_out(cfg_out));

// ### test/tb.sv
`timescale 1ns/1ns
module tb;
	logic               clk_sys_in = 1'b0;
	logic               reset_in = 1'b1;
	logic               cfg_write_in = 1'b0;
	otc_pkg::otc_cfg_t  cfg_in = otc_pkg::CFG_DEFAULT;
	otc_pkg::otc_refs_t refs_in = '{default: 16'h03e8};
	logic [15:0][15:0]  meas_in = '0;
	logic [3:0]         sw = 4'h0;
	logic               mux_o, oc_o, r1_o, r2_o;
	logic [16:0]        ao1_o, ao2_o;
	otc_pkg::otc_cfg_t  cfg_out, c;
	logic [3:0]         pins;
	logic [16:0]        pol[4] = '{17'h0271b, 17'h0271b, 17'h0044c, 17'h00000};
	logic [3:0]         st[4] = '{4'hf, 4'h0, 4'hf, 4'h7};
	logic [3:0]         ex[4] = '{4'h4, 4'hb, 4'hf, 4'h7};
	int                 n_mismatch = 0;
	int                 checks_done = 0;
	logic               t;
	int                 n = 0;
	int                 hp = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	otc_output_terminals #(.DELAY_TICK_CYCLES(10)) i_otc_output_terminals (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .cfg_write_in(cfg_write_in),
		.cfg_in(cfg_in), .refs_in(refs_in), .meas_in(meas_in), .switch_state_in(sw),
		.multiplex_output_terminal_out(mux_o), .open_collector_output_one_out(oc_o),
		.relay_one_contacts_out(r1_o), .relay_two_out(r2_o), .analog_output_one_out(ao1_o),
		.analog_output_two_out(ao2_o), .cfg_out(cfg_out));
	otc_plant i_otc_plant (.closed_in({mux_o, r2_o, r1_o, oc_o}), .pin_level_out(pins));
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task chk(input string what, input logic [159:0] exp, input logic [159:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// Write pulse lasts one clock, launched off the sampling edge
	task put_cfg(input otc_pkg::otc_cfg_t v);
		@(negedge clk_sys_in);
		cfg_in = v;
		cfg_write_in = 1'b1;
		@(negedge clk_sys_in);
		cfg_write_in = 1'b0;
	endtask : put_cfg
	task give_verdict;
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		// Sources chosen so that every scaled code except reserved code 9 lands on 50 %
		for (int i = 0; i < 16; i++)
			meas_in[i] = i == 5 ? 16'h0258 : (i >= 2 && i <= 4) ? 16'h03e8
				: (i == 6 || i >= 14) ? 16'h1388 : 16'h01f4;
		repeat (6) @(negedge clk_sys_in);
		reset_in = 1'b0;
		chk("defaults", otc_pkg::CFG_DEFAULT, cfg_out);
		c = otc_pkg::CFG_DEFAULT;
		c.pulse_fmax = 14'h3fff;
		c.ao1_gain = 11'h3ff;
		c.ao1_offset = 11'h400;
		c.delay[1] = 16'hffff;
		put_cfg(c);
		chk("fmax", 14'h2710, cfg_out.pulse_fmax);
		chk("gain", 11'h3e8, {cfg_out.ao1_gain});
		chk("offset", 11'h418, {cfg_out.ao1_offset});
		chk("delay", 16'h8ca0, cfg_out.delay[1]);
		c = otc_pkg::CFG_DEFAULT;
		c.ao2_gain = 11'h0c8;
		c.ao2_offset = 11'h79c;
		for (int i = 0; i < 16; i++)
		begin
			c.ao1_src = i[3:0];
			c.ao2_src = i[3:0];
			put_cfg(c);
			repeat (300) @(negedge clk_sys_in);
			chk("ao1", i == 9 ? 17'h00000 : 17'h0c350, ao1_o);
			chk("ao2", i == 9 ? 17'h00000 : 17'h15f90, ao2_o);
		end
		// Full scale clamps to 100.00 kHz; 50 % source gives 50.005 kHz, 499-cycle halves
		c.pulse_fmax = 14'h3fff;
		put_cfg(c);
		repeat (300) @(negedge clk_sys_in);
		t = mux_o;
		for (int k = 0; k < 1500 && n < 2; k++)
		begin
			@(negedge clk_sys_in);
			hp++;
			if (mux_o !== t)
			begin
				t = mux_o;
				n++;
				hp = n == 1 ? 0 : hp;
			end
		end
		if (n < 2)
		begin
			n_mismatch++;
			give_verdict();
		end
		chk("half period", 32'h0000_01f3, hp);
		c = otc_pkg::CFG_DEFAULT;
		c.mux_mode = otc_pkg::OTC_MODE_SWITCH;
		for (int i = 0; i < 4; i++)
		begin
			c.polarity = pol[i];
			sw = st[i];
			put_cfg(c);
			repeat (4) @(negedge clk_sys_in);
			chk("terminals", ex[i], {mux_o, r2_o, r1_o, oc_o});
			chk("pins", {~ex[i]}, pins);
		end
		// Short dip must restart the persistence count
		c.delay[0] = 16'h0005;
		sw = 4'h0;
		put_cfg(c);
		repeat (4) @(negedge clk_sys_in);
		sw = 4'h1;
		repeat (30) @(negedge clk_sys_in);
		sw = 4'h0;
		repeat (2) @(negedge clk_sys_in);
		sw = 4'h1;
		repeat (40) @(negedge clk_sys_in);
		chk("held", 1'b0, oc_o);
		repeat (15) @(negedge clk_sys_in);
		chk("late", 1'b1, oc_o);
		give_verdict();
	end
endmodule : tb
